// >>> hdl/frs_defs.vh
// Register map, field layout, reset values and timing counts for the reference selector
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH

`define FRS_ADDR_SOURCE        8'h00
`define FRS_ADDR_ANALOG        8'h04
`define FRS_ADDR_CONTACT       8'h08
`define FRS_ADDR_PULSE_SCALE   8'h0c
`define FRS_ADDR_MAX_FREQ      8'h10
`define FRS_ADDR_MONITOR       8'h14
`define FRS_ADDR_STATUS        8'h18
`define FRS_ADDR_PULSE_VALUE   8'h1c
`define FRS_ADDR_PRESET_BASE   8'h40
`define FRS_ADDR_JOG           8'h80

`define FRS_SRC_KEYPAD         3'h0
`define FRS_SRC_ANALOG         3'h1
`define FRS_SRC_SERIAL         3'h2
`define FRS_SRC_OPTION         3'h3
`define FRS_SRC_PULSE          3'h4
`define FRS_SRC_RESET          3'h1

`define FRS_PFN_FREQ           2'h0
`define FRS_PFN_MAX            2'h2
`define FRS_PFN_RESET          2'h0

`define FRS_AFN_ADD            5'h00
`define FRS_AFN_AUX1           5'h02
`define FRS_AFN_AUX2           5'h03
`define FRS_AFN_UNUSED         5'h1f
`define FRS_LVL_RESET          2'h0
`define FRS_AIN2_FN_RESET      5'h00
`define FRS_AIN3_FN_RESET      5'h1f

`define FRS_CFN_STEP1          8'h03
`define FRS_CFN_STEP2          8'h04
`define FRS_CFN_STEP3          8'h05
`define FRS_CFN_JOG            8'h06

`define FRS_SCALE_MIN          16'h03e8
`define FRS_SCALE_MAX          16'h7d00
`define FRS_SCALE_RESET        16'h05a0
`define FRS_MAX_FREQ_RESET     16'h1770

`define FRS_CLK_HZ             20000000
`define FRS_GATE_MS            100
`define FRS_GATE_CYCLES        ((`FRS_CLK_HZ / 1000) * `FRS_GATE_MS)
`define FRS_GATES_PER_S        (1000 / `FRS_GATE_MS)

`define FRS_RESP_OKAY          2'h0
`define FRS_RESP_SLVERR        2'h2

`endif

// >>> hdl/frs_contact_decode.v
// Decodes one multi-function contact input into step and jog selections
`timescale 1ns/1ps
`include "frs_defs.vh"
module frs_contact_decode (
  input  wire [7:0] func_code,
  input  wire       active,
  output wire       step1,
  output wire       step2,
  output wire       step3,
  output wire       jog
);
  assign step1 = active & (func_code == `FRS_CFN_STEP1);
  assign step2 = active & (func_code == `FRS_CFN_STEP2);
  assign step3 = active & (func_code == `FRS_CFN_STEP3);
  assign jog   = active & (func_code == `FRS_CFN_JOG);
endmodule

// >>> hdl/frs_pulse_scale.v
// Measures the pulse-train rate and scales it against maximum output frequency
`timescale 1ns/1ps
`include "frs_defs.vh"
module frs_pulse_scale #(
  parameter GATE_CYCLES = `FRS_GATE_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        pulse_sync,
  input  wire [15:0] scaling,
  input  wire [15:0] max_freq,
  output reg  [15:0] value_q
);
  localparam [15:0] GATES_PER_S = `FRS_GATES_PER_S;
  reg [31:0] gate_cnt_q;
  reg [15:0] edge_cnt_q;
  reg        pulse_prev_q;
  reg [35:0] num_q;
  reg [35:0] quo_q;
  reg [16:0] rem_q;
  reg [5:0]  div_cnt_q;
  wire       gate_end = (gate_cnt_q == GATE_CYCLES - 1);
  wire       rise     = pulse_sync & ~pulse_prev_q;
  wire [19:0] hz      = edge_cnt_q * GATES_PER_S[3:0];
  wire [16:0] rem_sh  = {rem_q[15:0], num_q[35]};
  wire        fits    = (rem_sh >= {1'b0, scaling});

  // Rate sampled over a fixed gate, then divided bit by bit to keep the area small
  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt_q   <= 32'h0;
      edge_cnt_q   <= 16'h0;
      pulse_prev_q <= 1'b0;
      num_q        <= 36'h0;
      quo_q        <= 36'h0;
      rem_q        <= 17'h0;
      div_cnt_q    <= 6'h0;
      value_q      <= 16'h0;
    end else begin
      pulse_prev_q <= pulse_sync;
      if (gate_end) begin
        gate_cnt_q <= 32'h0;
        edge_cnt_q <= {15'h0, rise};
        num_q      <= hz * max_freq;
        quo_q      <= 36'h0;
        rem_q      <= 17'h0;
        div_cnt_q  <= 6'h24;
      end else begin
        gate_cnt_q <= gate_cnt_q + 32'h1;
        if (rise && edge_cnt_q != 16'hffff) begin
          edge_cnt_q <= edge_cnt_q + 16'h1;
        end
        if (div_cnt_q != 6'h0) begin
          num_q     <= {num_q[34:0], 1'b0};
          rem_q     <= fits ? (rem_sh - {1'b0, scaling}) : rem_sh;
          quo_q     <= {quo_q[34:0], fits};
          div_cnt_q <= div_cnt_q - 6'h1;
          if (div_cnt_q == 6'h1) begin
            // Rates above the scaling saturate at maximum frequency
            if ({quo_q[34:0], fits} > {20'h0, max_freq}) begin
              value_q <= max_freq;
            end else begin
              value_q <= quo_q[14:0] * 16'h2 + {15'h0, fits};
            end
          end
        end
      end
    end
  end
endmodule

// >>> hdl/frs_top.v
// Frequency reference selector with its AXI4-Lite register slave
// Notes on behaviour
// - Source select accepts 0..4, resets to 1
// - Sources: keypad, analog, serial, option, pulse
// - Analog source sums input one and input two, input two only when set to add
// - Step one alone switches to input three when source is analog and input three is set to aux one
// - Source four takes the pulse-train rate when pulse function is 0, else zero
// - Pulse function accepts 0..2, resets 0
// - Scaling rate equals maximum output frequency
// - Sixteen presets plus one jog reference
// - Codes 3,4,5 give step bits
// - Code 6 selects jog, overriding steps
// - Step one also switches input two auxiliary
// - Step bits form binary preset index
`timescale 1ns/1ps
`include "frs_defs.vh"
module frs_top #(
  parameter AIN_W       = 12,
  parameter GATE_CYCLES = `FRS_GATE_CYCLES
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output wire [1:0]       s_axi_bresp,
  output wire             s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output wire [31:0]      s_axi_rdata,
  output wire [1:0]       s_axi_rresp,
  output wire             s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire             contact_terminal_five,
  input  wire             contact_terminal_six,
  input  wire             contact_terminal_seven,
  input  wire             contact_terminal_eight,
  input  wire             pulse_train_terminal,
  input  wire [AIN_W-1:0] analog_in_one,
  input  wire [AIN_W-1:0] analog_in_two,
  input  wire [AIN_W-1:0] analog_in_three,
  input  wire [15:0]      serial_reference,
  input  wire [15:0]      option_reference,
  output wire [15:0]      frequency_reference,
  output wire [15:0]      pid_pulse_value,
  output wire             jog_active
);
  reg         awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg  [1:0]  bresp_q, rresp_q;
  reg  [31:0] rdata_q;
  reg         aw_held_q, w_held_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  reg  [2:0]  reference_source_select_q;
  reg  [1:0]  pulse_input_function_select_q;
  reg  [1:0]  analog_in_two_level_select_q;
  reg  [4:0]  analog_in_two_function_select_q;
  reg  [4:0]  analog_in_three_function_select_q;
  reg  [31:0] contact_func_q;
  reg  [15:0] pulse_input_scaling_q;
  reg  [15:0] max_output_frequency_q;
  reg  [15:0] preset_q [0:16];

  reg  [4:0]  sync1_q, sync2_q;
  reg  [15:0] reference_monitor_q;
  reg  [15:0] pid_value_q;
  reg  [2:0]  index_q;
  reg         jog_q, aux_q;
  reg  [15:0] ref_d;
  reg         aux_d;

  wire [15:0] pulse_value;
  wire [3:0]  step1_v, step2_v, step3_v, jog_v;
  integer     i;

  // Two-stage synchronisers for contacts and the pulse pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 5'h0;
      sync2_q <= 5'h0;
    end else begin
      sync1_q <= {pulse_train_terminal, contact_terminal_eight, contact_terminal_seven,
                  contact_terminal_six, contact_terminal_five};
      sync2_q <= sync1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_contact
      frs_contact_decode u_dec (
        .func_code (contact_func_q[g*8 +: 8]),
        .active    (sync2_q[g]),
        .step1     (step1_v[g]),
        .step2     (step2_v[g]),
        .step3     (step3_v[g]),
        .jog       (jog_v[g])
      );
    end
  endgenerate

  frs_pulse_scale #(
    .GATE_CYCLES (GATE_CYCLES)
  ) u_pulse (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pulse_sync (sync2_q[4]),
    .scaling    (pulse_input_scaling_q),
    .max_freq   (max_output_frequency_q),
    .value_q    (pulse_value)
  );

  wire [2:0] index = {|step3_v, |step2_v, |step1_v};
  wire       jog   = |jog_v;

  // Analog counts scaled so full scale equals maximum output frequency
  wire [AIN_W+15:0] a1_prod = analog_in_one * max_output_frequency_q;
  wire [AIN_W+15:0] a2_prod = analog_in_two * max_output_frequency_q;
  wire [AIN_W+15:0] a3_prod = analog_in_three * max_output_frequency_q;
  wire [15:0] a1_f = a1_prod[AIN_W+15:AIN_W];
  wire [15:0] a2_f = a2_prod[AIN_W+15:AIN_W];
  wire [15:0] a3_f = a3_prod[AIN_W+15:AIN_W];
  wire        a2_add = (analog_in_two_function_select_q == `FRS_AFN_ADD);
  wire [16:0] master_sum = {1'b0, a1_f} + (a2_add ? {1'b0, a2_f} : 17'h0);
  wire [15:0] master_f = (master_sum > {1'b0, max_output_frequency_q}) ?
                         max_output_frequency_q : master_sum[15:0];
  wire        a3_aux1 = (analog_in_three_function_select_q == `FRS_AFN_AUX1);
  wire        a2_aux1 = (analog_in_two_function_select_q == `FRS_AFN_AUX1);
  wire        a3_aux2 = (analog_in_three_function_select_q == `FRS_AFN_AUX2);
  wire        pulse_is_freq = (pulse_input_function_select_q == `FRS_PFN_FREQ);

  // Base reference of the chosen source, used while no step bit is set
  reg  [15:0] base_f;
  always @* begin
    case (reference_source_select_q)
      `FRS_SRC_KEYPAD: base_f = preset_q[0];
      `FRS_SRC_ANALOG: base_f = master_f;
      `FRS_SRC_SERIAL: base_f = serial_reference;
      `FRS_SRC_OPTION: base_f = option_reference;
      `FRS_SRC_PULSE:  base_f = pulse_is_freq ? pulse_value : 16'h0;
      default:         base_f = 16'h0;
    endcase
  end

  // Jog first, then step index; step one routes to an auxiliary analog input when configured
  always @* begin
    aux_d = 1'b0;
    if (jog) begin
      ref_d = preset_q[16];
    end else if (index == 3'h0) begin
      ref_d = base_f;
    end else if (index == 3'h1 && reference_source_select_q == `FRS_SRC_ANALOG && a3_aux1) begin
      ref_d = a3_f;
      aux_d = 1'b1;
    end else if (index == 3'h1 && reference_source_select_q == `FRS_SRC_ANALOG && a2_aux1) begin
      ref_d = a2_f;
      aux_d = 1'b1;
    end else if (index == 3'h2 && reference_source_select_q == `FRS_SRC_ANALOG && a3_aux2) begin
      ref_d = a3_f;
      aux_d = 1'b1;
    end else begin
      ref_d = preset_q[index];
    end
  end

  // Fresh every cycle so a released contact drops its speed at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      reference_monitor_q <= 16'h0;
      pid_value_q         <= 16'h0;
      index_q             <= 3'h0;
      jog_q               <= 1'b0;
      aux_q               <= 1'b0;
    end else begin
      reference_monitor_q <= ref_d;
      pid_value_q         <= pulse_is_freq ? 16'h0 : pulse_value;
      index_q             <= index;
      jog_q               <= jog;
      aux_q               <= aux_d;
    end
  end

  // Register write path
  wire        wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire [31:0] wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire        wr_preset = (awaddr_q[7:6] == 2'b01);
  wire        wr_map  = (awaddr_q[1:0] == 2'b00) &&
                        (awaddr_q == `FRS_ADDR_SOURCE || awaddr_q == `FRS_ADDR_ANALOG ||
                         awaddr_q == `FRS_ADDR_CONTACT || awaddr_q == `FRS_ADDR_PULSE_SCALE ||
                         awaddr_q == `FRS_ADDR_MAX_FREQ || awaddr_q == `FRS_ADDR_JOG || wr_preset);
  reg  [31:0] old_word;
  always @* begin
    case (awaddr_q)
      `FRS_ADDR_SOURCE:      old_word = {26'h0, pulse_input_function_select_q, 1'b0,
                                         reference_source_select_q};
      `FRS_ADDR_ANALOG:      old_word = {11'h0, analog_in_three_function_select_q, 3'h0,
                                         analog_in_two_function_select_q, 6'h0, analog_in_two_level_select_q};
      `FRS_ADDR_CONTACT:     old_word = contact_func_q;
      `FRS_ADDR_PULSE_SCALE: old_word = {16'h0, pulse_input_scaling_q};
      `FRS_ADDR_MAX_FREQ:    old_word = {16'h0, max_output_frequency_q};
      `FRS_ADDR_JOG:         old_word = {16'h0, preset_q[16]};
      default:               old_word = {16'h0, preset_q[awaddr_q[5:2]]};
    endcase
  end
  wire [31:0] new_word = (old_word & ~wmask) | (wdata_q & wmask);

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FRS_RESP_OKAY;
      reference_source_select_q         <= `FRS_SRC_RESET;
      pulse_input_function_select_q     <= `FRS_PFN_RESET;
      analog_in_two_level_select_q      <= `FRS_LVL_RESET;
      analog_in_two_function_select_q   <= `FRS_AIN2_FN_RESET;
      analog_in_three_function_select_q <= `FRS_AIN3_FN_RESET;
      contact_func_q         <= {`FRS_CFN_JOG, `FRS_CFN_STEP3, `FRS_CFN_STEP2, `FRS_CFN_STEP1};
      pulse_input_scaling_q  <= `FRS_SCALE_RESET;
      max_output_frequency_q <= `FRS_MAX_FREQ_RESET;
      for (i = 0; i < 17; i = i + 1) begin
        preset_q[i] <= 16'h0;
      end
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? `FRS_RESP_OKAY : `FRS_RESP_SLVERR;
        if (wr_map) begin
          case (awaddr_q)
            `FRS_ADDR_SOURCE: begin
              // Out-of-range codes leave the field unchanged
              if (new_word[2:0] <= `FRS_SRC_PULSE) begin
                reference_source_select_q <= new_word[2:0];
              end
              if (new_word[5:4] <= `FRS_PFN_MAX) begin
                pulse_input_function_select_q <= new_word[5:4];
              end
            end
            `FRS_ADDR_ANALOG: begin
              analog_in_two_level_select_q      <= new_word[1:0];
              analog_in_two_function_select_q   <= new_word[12:8];
              analog_in_three_function_select_q <= new_word[20:16];
            end
            `FRS_ADDR_CONTACT: contact_func_q <= new_word;
            `FRS_ADDR_PULSE_SCALE: begin
              if (new_word[15:0] >= `FRS_SCALE_MIN && new_word[15:0] <= `FRS_SCALE_MAX) begin
                pulse_input_scaling_q <= new_word[15:0];
              end
            end
            `FRS_ADDR_MAX_FREQ: max_output_frequency_q <= new_word[15:0];
            `FRS_ADDR_JOG:      preset_q[16] <= new_word[15:0];
            default:            preset_q[awaddr_q[5:2]] <= new_word[15:0];
          endcase
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Register read path, one access outstanding
  reg  [31:0] rd_word;
  reg         rd_ok;
  always @* begin
    rd_ok = (s_axi_araddr[1:0] == 2'b00);
    case (s_axi_araddr)
      `FRS_ADDR_SOURCE:      rd_word = {26'h0, pulse_input_function_select_q, 1'b0,
                                        reference_source_select_q};
      `FRS_ADDR_ANALOG:      rd_word = {11'h0, analog_in_three_function_select_q, 3'h0,
                                        analog_in_two_function_select_q, 6'h0, analog_in_two_level_select_q};
      `FRS_ADDR_CONTACT:     rd_word = contact_func_q;
      `FRS_ADDR_PULSE_SCALE: rd_word = {16'h0, pulse_input_scaling_q};
      `FRS_ADDR_MAX_FREQ:    rd_word = {16'h0, max_output_frequency_q};
      `FRS_ADDR_MONITOR:     rd_word = {16'h0, reference_monitor_q};
      `FRS_ADDR_STATUS:      rd_word = {22'h0, aux_q, jog_q, 1'b0, index_q, 1'b0,
                                        reference_source_select_q};
      `FRS_ADDR_PULSE_VALUE: rd_word = {16'h0, pulse_value};
      `FRS_ADDR_JOG:         rd_word = {16'h0, preset_q[16]};
      default: begin
        rd_word = {16'h0, preset_q[s_axi_araddr[5:2]]};
        rd_ok   = rd_ok & (s_axi_araddr[7:6] == 2'b01);
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `FRS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_ok ? rd_word : 32'h0;
        rresp_q   <= rd_ok ? `FRS_RESP_OKAY : `FRS_RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign frequency_reference = reference_monitor_q;
  assign pid_pulse_value     = pid_value_q;
  assign jog_active          = jog_q;
endmodule

// >>> verif/frs_top_assertions.sv
// Port-level checks of the reference selector bus slave and jog selection
`timescale 1ns/1ps
module frs_top_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        contact_terminal_eight,
  input wire logic        jog_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_take_low: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after address take");
  a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("bvalid late after write take");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not idle after response");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late after address take");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before rready");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not idle after data");
  a_jog_on: assert property (contact_terminal_eight [*4] |-> jog_active)
    else $error("jog not active while jog contact held");
  a_jog_off: assert property (!contact_terminal_eight [*4] |-> !jog_active)
    else $error("jog still active after contact released");
endmodule
bind frs_top frs_top_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .contact_terminal_eight, .jog_active);

// >>> verif/frs_terminal_model.sv
// Control equipment model driving the contact and pulse-train terminals
`timescale 1ns/1ps
module frs_terminal_model #(
  parameter PULSE_HALF = 20
) (
  input  wire logic       aclk,
  input  wire logic [3:0] contacts_req,
  input  wire logic       pulse_en,
  output logic            contact_terminal_five,
  output logic            contact_terminal_six,
  output logic            contact_terminal_seven,
  output logic            contact_terminal_eight,
  output logic            pulse_train_terminal
);
  int cnt = 0;
  initial {contact_terminal_eight, contact_terminal_seven, contact_terminal_six, contact_terminal_five} = 4'h0;
  initial pulse_train_terminal = 1'b0;
  // Bit 0 drives the contact assigned to step one, bit 3 the jog contact
  always @(posedge aclk) begin
    {contact_terminal_eight, contact_terminal_seven, contact_terminal_six, contact_terminal_five} <= contacts_req;
  end
  // Period divides the gate window, so every window counts the same edges; line rests low when idle
  always @(posedge aclk) begin
    cnt <= (pulse_en && cnt < PULSE_HALF - 1) ? cnt + 1 : 0;
    if (!pulse_en)
      pulse_train_terminal <= 1'b0;
    else if (cnt == PULSE_HALF - 1)
      pulse_train_terminal <= ~pulse_train_terminal;
  end
endmodule

// >>> verif/frequency_reference_selector_tb.sv
// Self-checking bench for the frequency reference selector
`timescale 1ns/1ps
module frequency_reference_selector_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, jog_active;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] frequency_reference, pid_pulse_value;
  wire         contact_terminal_five, contact_terminal_six, contact_terminal_seven, contact_terminal_eight;
  wire         pulse_train_terminal;
  logic [11:0] analog_in_one = 12'h000, analog_in_two = 12'h000, analog_in_three = 12'h000;
  logic [15:0] serial_reference = 16'h1234, option_reference = 16'h2345;
  logic [3:0]  cont = 4'h0;
  logic        pen = 1'b0;
  int          num_errors = 0, n_tests = 0, cyc = 0;
  always #25 aclk = ~aclk;
  // Short gate window keeps the pulse test brief; expectations take edges per window times ten
  frs_top #(.GATE_CYCLES(2000)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .contact_terminal_five, .contact_terminal_six, .contact_terminal_seven, .contact_terminal_eight,
    .pulse_train_terminal, .analog_in_one, .analog_in_two, .analog_in_three, .serial_reference,
    .option_reference, .frequency_reference, .pid_pulse_value, .jog_active);
  frs_terminal_model u_term (.aclk, .contacts_req(cont), .pulse_en(pen), .contact_terminal_five,
    .contact_terminal_six, .contact_terminal_seven, .contact_terminal_eight, .pulse_train_terminal);
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input int dly = 0);
    bit aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= (dly == 0);
    aw = 1; w = 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin aw = 0; s_axi_awvalid <= 1'b0; end
      if (w && s_axi_wready === 1'b1) begin w = 0; s_axi_wvalid <= 1'b0; end
    end
    // A late bready makes the slave hold its response
    repeat (dly) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input int dly = 0);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= (dly == 0);
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // A late rready makes the slave hold its read data
    repeat (dly) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Contacts pass the model register and a two-stage synchroniser before selection
  task automatic fq(input logic [15:0] e, input int n = 6);
    repeat (n) @(posedge aclk);
    #1 chk("frequency_reference", {16'h0, frequency_reference}, {16'h0, e});
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h08, 32'h06050403, 2'h0);
    rd(8'h0c, 32'h5a0, 2'h0);
    rd(8'h10, 32'h1770, 2'h0);
    wr(8'h00, 32'h5, 2'h0); rd(8'h00, 32'h1, 2'h0);
    wr(8'h00, 32'h32, 2'h0); rd(8'h00, 32'h2, 2'h0);
    wr(8'h0c, 32'h3e7, 2'h0); rd(8'h0c, 32'h5a0, 2'h0);
    wr(8'h0c, 32'h7d00, 2'h0, 3); rd(8'h0c, 32'h7d00, 2'h0);
    wr(8'h14, 32'h0, 2'h2); rd(8'hf0, 32'h0, 2'h2);
    for (int n = 0; n < 16; n++) wr(8'h40 + 8'(4 * n), 32'h100 + n, 2'h0);
    wr(8'h80, 32'h0abc, 2'h0); rd(8'h7c, 32'h10f, 2'h0);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, s, 2'h0);
      fq(s == 0 ? 16'h100 : s == 1 ? 16'h0 : s == 2 ? 16'h1234 : 16'h2345);
    end
    wr(8'h00, 32'h0, 2'h0);
    for (int i = 0; i < 8; i++) begin
      cont <= 4'(i);
      fq(16'h100 + 16'(i));
    end
    rd(8'h14, 32'h107, 2'h0);
    cont <= 4'hf; fq(16'h0abc); chk("jog_active", {31'h0, jog_active}, 32'h1);
    cont <= 4'h0; fq(16'h100); chk("jog_active", {31'h0, jog_active}, 32'h0);
    s_axi_wstrb <= 4'h1; wr(8'h80, 32'hffee, 2'h0); s_axi_wstrb <= 4'hf; rd(8'h80, 32'h0aee, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    analog_in_one <= 12'h800; fq(16'h0bb8);
    analog_in_two <= 12'h400; fq(16'h1194);
    analog_in_one <= 12'hfff; analog_in_two <= 12'hfff; fq(16'h1770);
    wr(8'h04, 32'h00020000, 2'h0);
    analog_in_one <= 12'h800; analog_in_two <= 12'h000; analog_in_three <= 12'h200;
    cont <= 4'h1; fq(16'h02ee);
    rd(8'h18, 32'h211, 2'h0, 2);
    cont <= 4'h0; fq(16'h0bb8);
    wr(8'h04, 32'h00030000, 2'h0); cont <= 4'h2; fq(16'h02ee);
    wr(8'h04, 32'h001f0200, 2'h0);
    analog_in_two <= 12'h400; cont <= 4'h1; fq(16'h05dc);
    wr(8'h04, 32'h001f0002, 2'h0);
    analog_in_one <= 12'h000; analog_in_two <= 12'hc00; cont <= 4'h0; fq(16'h1194);
    // 50 edges per window, scaled against the minimum legal scaling of 1000
    wr(8'h0c, 32'h3e8, 2'h0); wr(8'h00, 32'h4, 2'h0);
    pen <= 1'b1; fq(16'h0bb8, 7000);
    wr(8'h00, 32'h14, 2'h0); fq(16'h0, 2500);
    chk("pid_pulse_value", {16'h0, pid_pulse_value}, 32'hbb8);
    rd(8'h1c, 32'hbb8, 2'h0);
    pen <= 1'b0;
    stop_test();
  end
endmodule
